// ### bench/iopr_host.sv
// Host model: serial master writing 16-bit frames
// Assumes the block samples mosi on rising spi_clk
module iopr_host
(
	// Serial link
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_mosi
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	// Clock stands still outside frames
	task automatic send(input logic [15:0] w);
		int i;
		#7 spi_cs_n = 1'b0;
		for (i = 15; i >= 0; i--)
		begin
			spi_mosi = w[i];
			#80 spi_clk = 1'b1;
			#80 spi_clk = 1'b0;
		end
		#80 spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
	endtask
endmodule

// ### bench/iopr_tb.sv
// Bench for the pin and enable registers
// Assumes iopr_host drives the serial link
`include "iopr_cfg.svh"
module io_pin_and_irq_enable_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import iopr_pkg::*;
	logic       core_clk, rst, can_fault, irq, seen;
	logic       spi_clk, spi_cs_n, spi_mosi;
	logic [7:0] io_cfg, irq_en;
	iopr_pins_t pins;
	int         n_errors, checked;
	iopr_host u_host (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi));
	iopr_regs u_dut (.core_clk(core_clk), .rst(rst), .spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .can_fault(can_fault),
		.pins(pins), .io_cfg(io_cfg), .irq_en(irq_en), .irq(irq));
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic chk(input logic [11:0] s, input logic [11:0] e);
		checked++;
		if (s !== e)
		begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Frame plus watch for an interrupt pulse meanwhile
	task automatic wr(input logic [1:0] c, input logic [4:0] a,
		input logic [7:0] d);
		seen = 1'b0;
		fork
			u_host.send({c, a, 1'b0, d});
			repeat (300) @(negedge core_clk) seen |= irq;
		join
	endtask
	task automatic t_reset;
		chk({4'h0, io_cfg}, 12'h000);
		chk({4'h0, irq_en}, 12'h000);
		chk(pins, 12'h000);
		chk({11'h0, irq}, 12'h000);
	endtask
	task automatic t_modes;
		logic [1:0] c;
		for (int k = 0; k < 4; k++)
		begin
			c = k[1:0];
			wr(2'h1, `IOPR_IO_CFG_ADDR, {4{c}});
			chk({4'h0, io_cfg}, {4'h0, {4{c}}});
			chk(pins, {{4{c == 2'h1}}, {2{c[1]}}, {2{c == 2'h3}}, 2'h0,
				{2{c == 2'h2}}});
		end
		wr(2'h1, `IOPR_IO_CFG_ADDR, 8'h1b);
		chk(pins, 12'h412);
	endtask
	task automatic t_refuse;
		wr(2'h2, `IOPR_IO_CFG_ADDR, 8'hff);
		wr(2'h1, 5'h13, 8'hff);
		chk({4'h0, io_cfg}, 12'h01b);
		chk({4'h0, irq_en}, 12'h000);
	endtask
	task automatic t_fault;
		@(negedge core_clk) can_fault = 1'b1;
		repeat (6) @(negedge core_clk);
		chk({11'h0, irq}, 12'h000);
		wr(2'h1, `IOPR_IRQ_EN_ADDR, 8'h80);
		chk({11'h0, irq}, 12'h001);
		chk({4'h0, io_cfg}, 12'h01b);
		can_fault = 1'b0;
		repeat (6) @(negedge core_clk);
		chk({11'h0, irq}, 12'h000);
	endtask
	task automatic t_host;
		wr(2'h1, `IOPR_IRQ_EN_ADDR, 8'h40);
		chk({11'h0, seen}, 12'h000);
		wr(2'h1, `IOPR_IRQ_EN_ADDR, 8'h44);
		chk({11'h0, seen}, 12'h001);
		chk({4'h0, irq_en}, 12'h044);
		chk({11'h0, irq}, 12'h000);
	endtask
	// Reset in mid-run, then one write to prove the link resumes
	task automatic t_rerun;
		@(negedge core_clk) rst = 1'b1;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		@(negedge core_clk);
		t_reset();
		wr(2'h1, `IOPR_IO_CFG_ADDR, 8'h80);
		chk({4'h0, io_cfg}, 12'h080);
		chk(pins, 12'h080);
	endtask
	initial
	begin
		#900000 n_errors++;
		finish_test();
	end
	initial
	begin
		rst = 1'b1;
		can_fault = 1'b0;
		seen = 1'b0;
		repeat (6) @(negedge core_clk);
		rst = 1'b0;
		@(negedge core_clk);
		t_reset();
		t_modes();
		t_refuse();
		t_fault();
		t_host();
		t_rerun();
		finish_test();
	end
endmodule

// ### common/iopr_cfg.svh
// Offsets, field positions and reset values of the pin and enable registers
// Assumes 16-bit frames, command in bits 15:14, address in bits 13:9
`ifndef IOPR_CFG_SVH
`define IOPR_CFG_SVH

`define IOPR_FRAME_BITS   16
`define IOPR_CNT_LAST     5'h0f
`define IOPR_CNT_DONE     5'h10
`define IOPR_CMD_HI       15
`define IOPR_CMD_LO       14
`define IOPR_CMD_WRITE    2'h1
`define IOPR_ADDR_HI      13
`define IOPR_ADDR_LO      9
`define IOPR_DATA_HI      7
`define IOPR_IO_CFG_ADDR  5'h11
`define IOPR_IRQ_EN_ADDR  5'h12
`define IOPR_REG_RESET    8'h00
`define IOPR_EN_CAN_BIT   7
`define IOPR_EN_HOST_BIT  6
`define IOPR_EN_SAFE_BIT  2
`define IOPR_HS_ONLY_MIN  2
`define IOPR_NUM_PINS     4

`endif

// ### common/iopr_pkg.sv
// Types of the pin and enable register bank
// Assumes iopr_cfg.svh holds the numeric constants
package iopr_pkg;

	typedef enum logic [1:0]
	{
		IOPR_OFF  = 2'h0,
		IOPR_WAKE = 2'h1,
		IOPR_LOW  = 2'h2,
		IOPR_HIGH = 2'h3
	} iopr_mode_t;

	typedef struct packed
	{
		logic [3:0] wake_en;
		logic [3:0] high_side_driver;
		logic [3:0] low_side_driver;
	} iopr_pins_t;

	typedef struct packed
	{
		logic [14:0] shift;
		logic [15:0] frame;
		logic        tgl;
	} iopr_link_t;

	typedef struct packed
	{
		logic       tgl_s1;
		logic       tgl_s2;
		logic       tgl_seen;
		logic       fault_s1;
		logic       fault_s2;
		logic [7:0] io_cfg;
		logic [7:0] irq_en;
		iopr_pins_t pins;
		logic       irq;
	} iopr_core_t;

endpackage

// ### hw/iopr_regs.sv
// Pin configuration and interrupt enable registers written by serial frames
// Assumes a serial master on spi_clk, frames framed by spi_cs_n
// Assumes can_fault is asynchronous to both clocks
//
// Functional notes
// R1: 0x11 sets pins 3,2; 1x high side
// R2: Pin 1: off, wake, low, high side
// R3: Pin 0: off, wake, low, high; reset zero
// R4: 0x12 enables; bit 7 gates CAN faults
// R5: Host writes address byte then data byte
// R6: Host interrupt needs bits 6 and 2
// R7: Interrupt only for enabled sources; keep config
`include "iopr_cfg.svh"

module iopr_regs
#(
	parameter int NUM_PINS = `IOPR_NUM_PINS
)
(
	// Core clock and reset
	input  wire logic         core_clk,
	input  wire logic         rst,
	// Serial link
	input  wire logic         spi_clk,
	input  wire logic         spi_cs_n,
	input  wire logic         spi_mosi,
	// Fault source
	input  wire logic         can_fault,
	// Register contents and pin controls
	output iopr_pkg::iopr_pins_t pins,
	output logic [7:0]        io_cfg,
	output logic [7:0]        irq_en,
	output logic              irq
);
	import iopr_pkg::*;

	// Register holds at most four two-bit pin fields
	if (NUM_PINS < 1 || NUM_PINS > `IOPR_NUM_PINS)
	begin : g_bad_pins
		$error("pin count not supported");
	end

	// Decode of one two-bit pin field
	function automatic iopr_pins_t pin_decode(input logic [1:0] code,
		input logic hs_only, input int idx);
		iopr_pins_t p;
		p = '0;
		p.wake_en[idx] = (code == IOPR_WAKE);
		if (code >= 2'(`IOPR_HS_ONLY_MIN))
		begin
			if (hs_only || code == IOPR_HIGH)
				p.high_side_driver[idx] = 1'b1;
			else
				p.low_side_driver[idx] = 1'b1;
		end
		return p;
	endfunction

	// Two-bit field of one pin
	function automatic logic [1:0] pin_field(input logic [7:0] cfg,
		input int idx);
		return cfg[2*idx +: 2];
	endfunction

	// Link domain
	iopr_link_t lk_r;
	iopr_link_t lk_nxt;
	logic [4:0] bit_cnt_r;
	logic       link_clr;

	assign link_clr = rst | spi_cs_n;

	// Bit position restarts with every frame select
	always_ff @(posedge spi_clk or posedge link_clr)
	begin
		if (link_clr)
			bit_cnt_r <= 5'h00;
		else if (bit_cnt_r != `IOPR_CNT_DONE)
			bit_cnt_r <= bit_cnt_r + 5'h01;
	end

	always_comb
	begin
		lk_nxt = lk_r;
		if (bit_cnt_r != `IOPR_CNT_DONE)
			lk_nxt.shift = {lk_r.shift[13:0], spi_mosi};
		// Word held still until next full frame; toggle marks it
		if (bit_cnt_r == `IOPR_CNT_LAST)
		begin
			lk_nxt.frame = {lk_r.shift, spi_mosi}; // R5
			lk_nxt.tgl   = ~lk_r.tgl;
		end
	end

	always_ff @(posedge spi_clk or posedge rst)
	begin
		if (rst)
			lk_r <= '0;
		else
			lk_r <= lk_nxt;
	end

	// Core domain
	iopr_core_t cr_r;
	iopr_core_t cr_nxt;
	logic       frame_new;
	logic       wr_ok;
	logic       wr_io;
	logic       wr_en;
	logic       host_fire;
	logic [7:0] wr_data;
	logic [4:0] wr_addr;

	always_comb
	begin
		cr_nxt          = cr_r;
		// Toggle and fault pin each pass two flops
		cr_nxt.tgl_s1   = lk_r.tgl;
		cr_nxt.tgl_s2   = cr_r.tgl_s1;
		cr_nxt.tgl_seen = cr_r.tgl_s2;
		cr_nxt.fault_s1 = can_fault;
		cr_nxt.fault_s2 = cr_r.fault_s1;

		frame_new = cr_r.tgl_s2 ^ cr_r.tgl_seen;
		wr_addr   = lk_r.frame[`IOPR_ADDR_HI:`IOPR_ADDR_LO];
		wr_data   = lk_r.frame[`IOPR_DATA_HI:0];
		wr_ok     = frame_new &&
			lk_r.frame[`IOPR_CMD_HI:`IOPR_CMD_LO] == `IOPR_CMD_WRITE; // R5
		wr_io     = wr_ok && wr_addr == `IOPR_IO_CFG_ADDR; // R1
		wr_en     = wr_ok && wr_addr == `IOPR_IRQ_EN_ADDR; // R4

		if (wr_io)
			cr_nxt.io_cfg = wr_data;
		if (wr_en)
			cr_nxt.irq_en = wr_data;

		// Host request fires once when both enables become set
		host_fire = wr_en && wr_data[`IOPR_EN_HOST_BIT]
			&& wr_data[`IOPR_EN_SAFE_BIT]
			&& !(cr_r.irq_en[`IOPR_EN_HOST_BIT]
			&& cr_r.irq_en[`IOPR_EN_SAFE_BIT]); // R6

		// Disabled sources only mask the output, never the stored fields
		cr_nxt.irq = (cr_r.fault_s2 && cr_r.irq_en[`IOPR_EN_CAN_BIT])
			|| host_fire; // R4 R7

		cr_nxt.pins = '0;
		for (int i = 0; i < NUM_PINS; i++)
		begin
			cr_nxt.pins = cr_nxt.pins | pin_decode(
				pin_field(cr_nxt.io_cfg, i), i >= 2, i); // R1 R2 R3
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cr_r        <= '0;
			cr_r.io_cfg <= `IOPR_REG_RESET; // R3
			cr_r.irq_en <= `IOPR_REG_RESET; // R4
		end
		else
			cr_r <= cr_nxt;
	end

	assign pins   = cr_r.pins;
	assign io_cfg = cr_r.io_cfg;
	assign irq_en = cr_r.irq_en;
	assign irq    = cr_r.irq;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	io_cfg_write_a: assert property ( // R1
		wr_io |=> io_cfg == $past(wr_data))
		else $error("pin config not written");

	irq_en_write_a: assert property ( // R4
		wr_en |=> irq_en == $past(wr_data))
		else $error("enable register not written");

	pin_hs_upper_a: assert property ( // R1
		pins.high_side_driver[3] == io_cfg[7]
		&& pins.high_side_driver[2] == io_cfg[5]
		&& !pins.low_side_driver[3] && !pins.low_side_driver[2])
		else $error("upper pin decode wrong");

	pin_one_decode_a: assert property ( // R2
		pins.low_side_driver[1] == (io_cfg[3:2] == IOPR_LOW)
		&& pins.high_side_driver[1] == (io_cfg[3:2] == IOPR_HIGH)
		&& pins.wake_en[1] == (io_cfg[3:2] == IOPR_WAKE))
		else $error("pin 1 decode wrong");

	pin_zero_decode_a: assert property ( // R3
		pins.wake_en[0] == (io_cfg[1:0] == IOPR_WAKE)
		&& pins.low_side_driver[0] == (io_cfg[1:0] == IOPR_LOW))
		else $error("pin 0 decode wrong");

	can_irq_raise_a: assert property ( // R4
		can_fault && irq_en[`IOPR_EN_CAN_BIT]
		##1 irq_en[`IOPR_EN_CAN_BIT] [*2] |=> irq)
		else $error("enabled fault gave no interrupt");

	irq_masked_a: assert property ( // R7
		!cr_r.fault_s2 && !host_fire |=> !irq)
		else $error("interrupt without enabled source");

	host_req_once_a: assert property ( // R6
		$rose(irq_en[`IOPR_EN_HOST_BIT] && irq_en[`IOPR_EN_SAFE_BIT])
		|-> $past(host_fire) && irq)
		else $error("host request interrupt missing");

	cfg_hold_a: assert property ( // R7
		!wr_io && !wr_en |=> $stable(io_cfg) && $stable(irq_en))
		else $error("configuration lost");

	// Register writes by address
	io_addr_decode_a: assert property ( // R1
		frame_new && lk_r.frame[`IOPR_CMD_HI:`IOPR_CMD_LO] == `IOPR_CMD_WRITE
		&& lk_r.frame[`IOPR_ADDR_HI:`IOPR_ADDR_LO] == `IOPR_IO_CFG_ADDR
		|=> io_cfg == $past(wr_data))
		else $error("write to pin config lost");

	en_addr_decode_a: assert property ( // R4
		frame_new && lk_r.frame[`IOPR_CMD_HI:`IOPR_CMD_LO] == `IOPR_CMD_WRITE
		&& lk_r.frame[`IOPR_ADDR_HI:`IOPR_ADDR_LO] == `IOPR_IRQ_EN_ADDR
		|=> irq_en == $past(wr_data))
		else $error("write to enable register lost");

	io_cfg_hold_a: assert property ( // R7
		!wr_io |=> $stable(io_cfg))
		else $error("pin config changed unasked");

	irq_en_hold_a: assert property ( // R7
		!wr_en |=> $stable(irq_en))
		else $error("enable register changed unasked");

	// Frame handling
	frame_once_a: assert property ( // R5
		frame_new |=> !frame_new)
		else $error("one frame taken twice");

	cmd_refuse_a: assert property ( // R5
		frame_new && lk_r.frame[`IOPR_CMD_HI:`IOPR_CMD_LO]
		!= `IOPR_CMD_WRITE |=> $stable(io_cfg) && $stable(irq_en))
		else $error("refused frame changed a register");

	// Pin decode
	pin_upper_wake_a: assert property ( // R1
		pins.wake_en[3] == (io_cfg[7:6] == IOPR_WAKE)
		&& pins.wake_en[2] == (io_cfg[5:4] == IOPR_WAKE))
		else $error("upper pin wake decode wrong");

	pin_zero_high_a: assert property ( // R3
		pins.high_side_driver[0] == (io_cfg[1:0] == IOPR_HIGH))
		else $error("pin 0 high side decode wrong");

	pins_exclusive_a: assert property ( // R1 R2 R3
		(pins.wake_en & pins.high_side_driver) == 4'h0
		&& (pins.wake_en & pins.low_side_driver) == 4'h0
		&& (pins.high_side_driver & pins.low_side_driver) == 4'h0)
		else $error("pin has two modes at once");

	// One check per pin field
	for (genvar g = 0; g < NUM_PINS; g++)
	begin : g_pin_chk
		pin_off_a: assert property ( // R1 R2 R3
			pin_field(io_cfg, g) == IOPR_OFF |->
			!pins.wake_en[g] && !pins.high_side_driver[g]
			&& !pins.low_side_driver[g])
			else $error("disabled pin still active");
	end

	// Interrupt path
	can_irq_hold_a: assert property ( // R4
		cr_r.fault_s2 && irq_en[`IOPR_EN_CAN_BIT] |=> irq)
		else $error("enabled fault interrupt dropped");

	can_irq_mask_a: assert property ( // R7
		cr_r.fault_s2 && !irq_en[`IOPR_EN_CAN_BIT] && !host_fire
		|=> !irq)
		else $error("disabled fault raised interrupt");

	can_irq_fall_a: assert property ( // R7
		!can_fault [*3] ##0 !host_fire |=> !irq)
		else $error("interrupt outlived its fault");

	irq_source_a: assert property ( // R7
		irq |-> $past(host_fire
		|| (cr_r.fault_s2 && irq_en[`IOPR_EN_CAN_BIT])))
		else $error("interrupt without a cause");

	host_pulse_end_a: assert property ( // R6
		host_fire ##1 !cr_r.fault_s2 |=> !irq)
		else $error("host request interrupt repeated");

	cover_io_write_c: cover property (wr_io ##1 pins.high_side_driver[3]);
	cover_can_irq_c: cover property (cr_r.fault_s2 ##1 irq);
	cover_host_irq_c: cover property (host_fire ##1 irq);
	cover_refused_c: cover property (frame_new && !wr_ok);
	cover_pin_low_c: cover property (wr_io ##1 pins.low_side_driver[1]);
endmodule
